// File: rtl/ddsl_top.sv
// dual dac serial load, strobe transfer, clear and power-down logic
// assumes serial_clk, serial_in and chip_select_n come from the host
// in one timing domain; strobes and control pins are asynchronous
//
// Function
// [R1] 12-bit: drop top four bits, keep twelve
// [R2] 10-bit: drop top six bits, keep ten
// [R3] host shifts bit 15 first, down to 0
// [R4] power-down low disables both output amplifiers
// [R5] dac registers hold their codes during power-down; here a clear still overwrites them
// [R6] wake restores codes, outputs settle after 80 us
// [R7] dac code is straight binary for unipolar
// [R8] host treats ten-bit code as offset binary
// [R9] unused power-down input tied high by system
// [R10] shift serial data on rising serial clock
// [R11] shift only while chip select low
// [R12] low strobe copies shift word into dac
// [R13] clear sets zero, or midscale when selected
// [R14] only the last resolution bits are kept
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ddsl_top #(
  parameter int unsigned CODE_W     = ddsl_pkg::CODE_W_DEF,
  parameter int unsigned SETTLE_CYC = ddsl_pkg::SETTLE_CYC
) (
  input  wire logic              ref_clk,         // system clock
  input  wire logic              reset,           // async, active high
  input  wire logic              hsel,            // ahb slave select
  input  wire logic [31:0]       haddr,           // ahb address
  input  wire logic [1:0]        htrans,          // ahb transfer type
  input  wire logic              hwrite,          // ahb write
  input  wire logic [2:0]        hsize,           // ahb size
  input  wire logic [31:0]       hwdata,          // ahb write data
  input  wire logic              hready,          // ahb bus ready
  output logic                   hreadyout,       // ahb slave ready
  output logic [31:0]            hrdata,          // ahb read data
  output logic                   hresp,           // ahb response
  input  wire logic              serial_clk,      // host serial clock
  input  wire logic              serial_in,       // serial data
  input  wire logic              chip_select_n,   // frame select
  input  wire logic              load_strobe_a_n, // load dac a
  input  wire logic              load_strobe_b_n, // load dac b
  input  wire logic              async_clear_n,   // clear both dacs
  input  wire logic              midscale_sel,    // clear to midscale
  input  wire logic              power_down_n,    // shutdown pin
  output logic [CODE_W-1:0]      dac_code_a,      // code to dac a
  output logic [CODE_W-1:0]      dac_code_b,      // code to dac b
  output logic                   amp_enable_a,    // amplifier a on
  output logic                   amp_enable_b,    // amplifier b on
  output logic                   output_settled   // outputs valid
);

  localparam int unsigned CNT_W = $clog2(SETTLE_CYC + 1);
  localparam logic [CODE_W-1:0] MID_CODE = {1'b1, {(CODE_W-1){1'b0}}};
  localparam logic [CODE_W-1:0] ZERO_CODE = '0;

  logic [ddsl_pkg::SHIFT_W-1:0] shift_word;
  logic [ddsl_pkg::SHIFT_W-1:0] capture;
  logic [ddsl_pkg::PIN_W-1:0]   pin_raw;
  logic [ddsl_pkg::PIN_W-1:0]   sync_q1;
  logic [ddsl_pkg::PIN_W-1:0]   sync_q2;
  logic                         cs_hold;
  logic                         cs_idle;
  logic                         pd_eff;
  logic                         clr_go;
  logic [CODE_W-1:0]            clear_val;
  logic [CODE_W-1:0]            dac_reg [2];
  logic [1:0]                   load_go;
  ddsl_pkg::ddsl_pwr_t          pwr_state;
  logic [CNT_W-1:0]             settle_cnt;
  logic                         amp_on;
  logic                         ctrl_pd;
  logic                         sw_clr;
  logic                         ap_go;
  logic                         dp_write;
  logic [7:0]                   dp_addr;
  logic [31:0]                  next_rdata;

  // link domain: shift register on the host clock
  always_ff @(posedge serial_clk or posedge reset) begin
    if (reset) begin
      shift_word <= '0;
    end else if (!chip_select_n) begin // see [R11]
      // msb arrives first and ends up on top // see [R10]
      shift_word <= {shift_word[ddsl_pkg::SHIFT_W-2:0], serial_in};
    end
  end

  a_shift_gated: assert property ( // see [R11]
    @(posedge serial_clk) disable iff (reset)
    chip_select_n |=> $stable(shift_word))
    else $error("shift register moved with chip select high");

  a_shift_order: assert property ( // see [R10]
    @(posedge serial_clk) disable iff (reset)
    !chip_select_n |=> (shift_word[0] == $past(serial_in)) &&
      (shift_word[ddsl_pkg::SHIFT_W-1:1] ==
       $past(shift_word[ddsl_pkg::SHIFT_W-2:0])))
    else $error("serial bit not shifted in at the bottom");

  // pin synchronisers into ref_clk
  assign pin_raw = {chip_select_n, load_strobe_a_n, load_strobe_b_n,
                    async_clear_n, midscale_sel, power_down_n};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync_q1 <= ddsl_pkg::PIN_RESET;
      sync_q2 <= ddsl_pkg::PIN_RESET;
    end else begin
      sync_q1 <= pin_raw;
      sync_q2 <= sync_q1;
    end
  end

  // copy the shift word once, when the raised select has crossed over;
  // the host clock has stopped by then, so no bit is still moving
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cs_hold <= 1'b0;
      capture <= '0;
    end else begin
      cs_hold <= sync_q2[ddsl_pkg::PIN_CS];
      if (sync_q2[ddsl_pkg::PIN_CS] && !cs_hold) begin
        capture <= shift_word;
      end
    end
  end

  a_capture_frozen: assert property ( // see [R11]
    @(posedge ref_clk) disable iff (reset)
    cs_hold |=> $stable(capture))
    else $error("captured word moved while the link was idle");

  assign cs_idle   = sync_q2[ddsl_pkg::PIN_CS] & cs_hold;
  assign pd_eff    = ~sync_q2[ddsl_pkg::PIN_PD] | ctrl_pd;
  assign clr_go    = ~sync_q2[ddsl_pkg::PIN_CLR] | sw_clr;
  // see [R13]
  assign clear_val = sync_q2[ddsl_pkg::PIN_MID] ? MID_CODE : ZERO_CODE;

  // dac registers, one per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    // level-sensitive strobe, held off in shutdown // see [R12] [R5]
    assign load_go[ch] = ~sync_q2[ddsl_pkg::PIN_LDA-ch] & cs_idle &
                         ~pd_eff;

    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        dac_reg[ch] <= '0;
      end else if (clr_go) begin // see [R13]
        dac_reg[ch] <= clear_val;
      end else if (load_go[ch]) begin
        // low bits only, upper positions ignored // see [R1] [R2] [R14]
        dac_reg[ch] <= capture[CODE_W-1:0];
      end
    end

    a_load_copy: assert property ( // see [R12]
      @(posedge ref_clk) disable iff (reset)
      load_go[ch] && !clr_go |=>
        dac_reg[ch] == $past(capture[CODE_W-1:0]))
      else $error("strobe did not copy the last shifted bits");

    a_clear_value: assert property ( // see [R13]
      @(posedge ref_clk) disable iff (reset)
      clr_go |=> dac_reg[ch] ==
        ($past(sync_q2[ddsl_pkg::PIN_MID]) ? MID_CODE : ZERO_CODE))
      else $error("clear gave the wrong code");

    a_pd_hold: assert property ( // see [R5]
      @(posedge ref_clk) disable iff (reset)
      pd_eff && !clr_go |=> $stable(dac_reg[ch]))
      else $error("dac register changed during shutdown");

    a_load_blocked: assert property ( // see [R11]
      @(posedge ref_clk) disable iff (reset)
      !cs_idle && !clr_go |=> $stable(dac_reg[ch]))
      else $error("dac register loaded while a frame was open");
  end

  // straight binary code straight to the converters // see [R7]
  assign dac_code_a = dac_reg[0];
  assign dac_code_b = dac_reg[1];

  // power state: off, waking while outputs settle, on
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pwr_state  <= ddsl_pkg::DDSL_PWR_OFF;
      settle_cnt <= '0;
    end else begin
      case (pwr_state)
        ddsl_pkg::DDSL_PWR_OFF: begin
          if (!pd_eff) begin // see [R6]
            pwr_state  <= ddsl_pkg::DDSL_PWR_WAKE;
            settle_cnt <= CNT_W'(SETTLE_CYC - 1);
          end
        end
        ddsl_pkg::DDSL_PWR_WAKE: begin
          if (pd_eff) begin
            pwr_state <= ddsl_pkg::DDSL_PWR_OFF;
          end else if (settle_cnt == '0) begin
            pwr_state <= ddsl_pkg::DDSL_PWR_ON;
          end else begin
            settle_cnt <= settle_cnt - 1'b1;
          end
        end
        ddsl_pkg::DDSL_PWR_ON: begin
          if (pd_eff) begin
            pwr_state <= ddsl_pkg::DDSL_PWR_OFF;
          end
        end
        default: begin
          pwr_state <= ddsl_pkg::DDSL_PWR_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      amp_on <= 1'b0;
    end else begin
      amp_on <= ~pd_eff; // see [R4]
    end
  end

  assign amp_enable_a   = amp_on;
  assign amp_enable_b   = amp_on;
  assign output_settled = (pwr_state == ddsl_pkg::DDSL_PWR_ON);

  a_pd_amp: assert property ( // see [R4]
    @(posedge ref_clk) disable iff (reset)
    pd_eff |=> !amp_enable_a && !amp_enable_b)
    else $error("amplifier left on in shutdown");

  a_amp_wake: assert property ( // see [R4]
    @(posedge ref_clk) disable iff (reset)
    !pd_eff |=> amp_enable_a && amp_enable_b)
    else $error("amplifier still off after wake");

  a_settle_drop: assert property ( // see [R6]
    @(posedge ref_clk) disable iff (reset)
    pd_eff |=> !output_settled)
    else $error("outputs marked valid during shutdown");

  a_settle_rise: assert property ( // see [R6]
    @(posedge ref_clk) disable iff (reset)
    $rose(output_settled) |->
      $past(settle_cnt) == '0 &&
      $past(pwr_state) == ddsl_pkg::DDSL_PWR_WAKE)
    else $error("outputs valid before settling count ran out");

  a_wake_start: assert property ( // see [R6]
    @(posedge ref_clk) disable iff (reset)
    pwr_state == ddsl_pkg::DDSL_PWR_OFF && !pd_eff |=>
      pwr_state == ddsl_pkg::DDSL_PWR_WAKE &&
      settle_cnt == CNT_W'(SETTLE_CYC - 1))
    else $error("wake did not load the settling count");

  a_wake_count: assert property ( // see [R6]
    @(posedge ref_clk) disable iff (reset)
    pwr_state == ddsl_pkg::DDSL_PWR_WAKE && !pd_eff &&
      settle_cnt != '0 |=> settle_cnt == $past(settle_cnt) - 1'b1)
    else $error("settling count did not step down");

  a_settled_hold: assert property ( // see [R6]
    @(posedge ref_clk) disable iff (reset)
    output_settled && !pd_eff |=> output_settled)
    else $error("outputs dropped valid without shutdown");

  // ahb-lite slave, zero wait states
  assign ap_go     = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    next_rdata = 32'h0;
    case (haddr[7:0])
      ddsl_pkg::ADDR_CODE_A: begin
        next_rdata[CODE_W-1:0] = dac_reg[0];
      end
      ddsl_pkg::ADDR_CODE_B: begin
        next_rdata[CODE_W-1:0] = dac_reg[1];
      end
      ddsl_pkg::ADDR_CTRL: begin
        next_rdata[ddsl_pkg::CTRL_PD_BIT] = ctrl_pd;
      end
      ddsl_pkg::ADDR_STATUS: begin
        next_rdata[ddsl_pkg::ST_PD_BIT]      = pd_eff;
        next_rdata[ddsl_pkg::ST_SETTLED_BIT] = output_settled;
        next_rdata[ddsl_pkg::ST_AMP_BIT]     = amp_on;
        next_rdata[ddsl_pkg::ST_IDLE_BIT]    = cs_idle;
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      hrdata   <= 32'h0;
    end else begin
      dp_write <= ap_go & hwrite & (hsize == ddsl_pkg::HSIZE_WORD);
      if (ap_go) begin
        dp_addr <= haddr[7:0];
      end
      hrdata <= (ap_go && !hwrite) ? next_rdata : 32'h0;
    end
  end

  // control: forced shutdown level and a one-cycle clear pulse
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_pd <= ddsl_pkg::CTRL_PD_RST;
      sw_clr  <= 1'b0;
    end else begin
      sw_clr <= 1'b0;
      if (dp_write && dp_addr == ddsl_pkg::ADDR_CTRL) begin
        ctrl_pd <= hwdata[ddsl_pkg::CTRL_PD_BIT];
        sw_clr  <= hwdata[ddsl_pkg::CTRL_CLR_BIT];
      end
    end
  end

  a_bus_read: assert property (
    @(posedge ref_clk) disable iff (reset)
    ap_go && !hwrite && haddr[7:0] == ddsl_pkg::ADDR_CODE_A |=>
      hrdata[CODE_W-1:0] == $past(dac_reg[0]))
    else $error("code a read back wrong");

  a_bus_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    dp_write && dp_addr == ddsl_pkg::ADDR_CTRL |=>
      ctrl_pd == $past(hwdata[ddsl_pkg::CTRL_PD_BIT]))
    else $error("control write did not set the shutdown bit");

  a_ctrl_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(dp_write && dp_addr == ddsl_pkg::ADDR_CTRL) |=> $stable(ctrl_pd))
    else $error("shutdown bit changed without a control write");

  a_read_idle: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(ap_go && !hwrite) |=> hrdata == 32'h0)
    else $error("read data shown outside a read data phase");

endmodule
`default_nettype wire

// File: rtl/ddsl_pkg.sv
// constants of the dual serial dac front end
// assumes a 100 MHz ref_clk and an AHB-Lite master with 32-bit data
package ddsl_pkg;
  localparam int unsigned SHIFT_W     = 16;
  localparam int unsigned CODE_W_DEF  = 12;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SETTLE_US   = 80;
  localparam int unsigned SETTLE_CYC  = SETTLE_US * CLK_MHZ;
  // register byte offsets
  localparam logic [7:0] ADDR_CODE_A  = 8'h00;
  localparam logic [7:0] ADDR_CODE_B  = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  // control fields
  localparam int unsigned CTRL_PD_BIT  = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam logic        CTRL_PD_RST  = 1'b0;
  // status fields
  localparam int unsigned ST_PD_BIT      = 0;
  localparam int unsigned ST_SETTLED_BIT = 1;
  localparam int unsigned ST_AMP_BIT     = 2;
  localparam int unsigned ST_IDLE_BIT    = 3;
  // synchronised pins: cs, strobe a, strobe b, clear, midscale, pd
  localparam int unsigned PIN_W      = 6;
  localparam int unsigned PIN_CS     = 5;
  localparam int unsigned PIN_LDA    = 4;
  localparam int unsigned PIN_CLR    = 2;
  localparam int unsigned PIN_MID    = 1;
  localparam int unsigned PIN_PD     = 0;
  localparam logic [5:0]  PIN_RESET  = 6'h3d;
  localparam logic [1:0]  HTRANS_BIT = 2'h2;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {
    DDSL_PWR_OFF  = 2'h0,
    DDSL_PWR_WAKE = 2'h1,
    DDSL_PWR_ON   = 2'h3
  } ddsl_pwr_t;
endpackage

// File: dv/ddsl_host_model.sv
// host side of the serial link: frames shifted msb first
// assumes the bench calls send() and waits for it to return
`timescale 1ns/1ps
`default_nettype none
module ddsl_host_model (
  output logic serial_clk,    // link clock, still between frames
  output logic serial_in,     // serial data
  output logic chip_select_n  // frame select
);
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b1;
    chip_select_n = 1'b1;
  end
  // n bits of w, 12 ns per bit; sel low sends clocks without select
  task automatic send(input logic [31:0] w, input int n, input bit sel);
    chip_select_n = !sel;
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    #3 chip_select_n = 1'b1;
    serial_in = !serial_in;
  endtask
endmodule
`default_nettype wire

// File: dv/dual_dac_serial_load_shutdown_tb_top.sv
// bench for ddsl_top, 12-bit and 10-bit instances side by side
// assumes ddsl_pkg and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_shutdown_tb_top;
  localparam int unsigned CW = 12;
  logic        ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h80c6;
  logic [31:0] rd, ea, eb;
  logic        hreadyout, hresp, serial_clk, serial_in, chip_select_n;
  logic        load_strobe_a_n = 1'b1, load_strobe_b_n = 1'b1;
  logic        async_clear_n = 1'b1, midscale_sel = 1'b0;
  logic        power_down_n = 1'b1;
  logic [CW-1:0] dac_code_a, dac_code_b;
  logic [9:0]  c10_a;
  logic        amp_enable_a, amp_enable_b, output_settled;
  wire logic   hready;
  int          num_errors = 0, n_compared = 0, cycles = 0;
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  ddsl_host_model host (.serial_clk, .serial_in, .chip_select_n);
  ddsl_top #(.CODE_W(CW), .SETTLE_CYC(20)) DUT (.ref_clk, .reset, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hrdata, .hresp, .serial_clk, .serial_in, .chip_select_n,
    .load_strobe_a_n, .load_strobe_b_n, .async_clear_n, .midscale_sel,
    .power_down_n, .dac_code_a, .dac_code_b, .amp_enable_a,
    .amp_enable_b, .output_settled);
  ddsl_top #(.CODE_W(10), .SETTLE_CYC(20)) DUT_S (.ref_clk, .reset,
    .hsel(1'b0), .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(), .hrdata(), .hresp(), .serial_clk, .serial_in,
    .chip_select_n, .load_strobe_a_n, .load_strobe_b_n, .async_clear_n,
    .midscale_sel, .power_down_n, .dac_code_a(c10_a), .dac_code_b(),
    .amp_enable_a(), .amp_enable_b(), .output_settled());
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] keep(input logic [31:0] w, input int n);
    return w & ((32'h1 << n) - 32'h1);
  endfunction
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= ddsl_pkg::HTRANS_BIT;
    hwrite <= wr;
    hsize <= ddsl_pkg::HSIZE_WORD;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp, 32'h0);
    hsel <= 1'b0;
  endtask
  // frame then enough ref_clk edges for the link to show idle
  task automatic frame(input logic [31:0] w, input int n, input bit sel);
    host.send(w, n, sel);
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic load(input bit a, input bit b);
    @(posedge ref_clk);
    load_strobe_a_n <= !a;
    load_strobe_b_n <= !b;
    repeat (6) @(posedge ref_clk);
    load_strobe_a_n <= 1'b1;
    load_strobe_b_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic pins(input logic clr_n, input logic pd_n);
    @(posedge ref_clk);
    async_clear_n <= clr_n;
    power_down_n <= pd_n;
    repeat (6) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ahb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    ea = 0;
    eb = 0;
    for (int i = 0; i < 15; i++) begin
      seed = lfsr(seed);
      if (i == 12) seed[15:0] = 16'hffff;
      if (i == 13) seed[15:0] = 16'h0800;
      if (i == 14) seed[15:0] = 16'hf200;
      frame(seed, 16, 1'b1);
      load(i % 3 != 1, i % 3 != 0);
      if (i % 3 != 1) ea = keep(seed, CW);
      if (i % 3 != 0) eb = keep(seed, CW);
      check(dac_code_a, ea);
      check(dac_code_b, eb);
      if (i % 3 != 1) check(c10_a, keep(seed, 10));
      if (i == 13) check(dac_code_b, 32'h800);
      if (i == 14) check(c10_a, 32'h200);
    end
    seed = lfsr(seed);
    frame(seed, 20, 1'b1);
    load(1'b1, 1'b0);
    ea = keep(seed, CW);
    check(dac_code_a, ea);
    frame(~seed, 16, 1'b0);
    load(1'b1, 1'b0);
    check(dac_code_a, ea);
    ahb(1'b0, ddsl_pkg::ADDR_CODE_A, 32'h0);
    check(rd, ea);
    for (int m = 0; m < 2; m++) begin
      midscale_sel <= m[0];
      pins(1'b0, 1'b1);
      pins(1'b1, 1'b1);
      check(dac_code_b, m ? 32'h1 << (CW - 1) : 32'h0);
      check(c10_a, m ? 32'h200 : 32'h0);
    end
    frame(seed, 16, 1'b1);
    load(1'b1, 1'b1);
    eb = keep(seed, CW);
    pins(1'b1, 1'b0);
    check({amp_enable_a, amp_enable_b, output_settled}, 32'h0);
    frame(~seed, 16, 1'b1);
    load(1'b1, 1'b1);
    check(dac_code_b, eb);
    pins(1'b1, 1'b1);
    check({amp_enable_a, amp_enable_b, output_settled}, 32'h6);
    for (int k = 0; k < 40 && output_settled !== 1'b1; k++)
      @(posedge ref_clk);
    check(output_settled, 32'h1);
    check(dac_code_a, eb);
    ahb(1'b1, ddsl_pkg::ADDR_CTRL, 32'h1);
    repeat (6) @(posedge ref_clk);
    ahb(1'b0, ddsl_pkg::ADDR_STATUS, 32'h0);
    check(rd, (32'h1 << ddsl_pkg::ST_PD_BIT) |
              (32'h1 << ddsl_pkg::ST_IDLE_BIT));
    check(amp_enable_a, 32'h0);
    midscale_sel <= 1'b0;
    ahb(1'b1, ddsl_pkg::ADDR_CTRL, 32'h2);
    repeat (6) @(posedge ref_clk);
    check(dac_code_a, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
